// file: dxd_params.svh
// constants for the serial command word decoder: fields, codes, reset values
`ifndef DXD_PARAMS_SVH
`define DXD_PARAMS_SVH

// ==========================================
// command word layout
`define DXD_WORD_W 16
`define DXD_CHAN_LSB 0
`define DXD_CHAN_MSB 3
`define DXD_SUB_LSB 4
`define DXD_SUB_MSB 7
`define DXD_CODE_LSB 8
`define DXD_CODE_MSB 15
`define DXD_XPAY_LSB 4

// ==========================================
// channel field codes
`define DXD_CH_SPECIAL 4'h0
`define DXD_CH_FIRST 4'h1
`define DXD_CH_LAST 4'hC
`define DXD_CH_SHARED_FIRST 4'h5
`define DXD_CH_XOUT 4'hD
`define DXD_CH_XIN 4'hE
`define DXD_CH_DIR 4'hF

// ==========================================
// sub-codes in bits 7..4
`define DXD_SUB_LOAD 4'h0
`define DXD_SUB_HIZ 4'h1
`define DXD_SUB_ALL_LOAD 4'hC
`define DXD_SUB_ALL_HIZ 4'hD
`define DXD_SUB_RESET 4'hE

// ==========================================
// reset values
`define DXD_DAC_RST 8'h00
`define DXD_DIR_RST 12'h000
`define DXD_PAR_RST 12'h000
`define DXD_SR_RST 16'h0000

`endif

// file: dxd_pkg.sv
// types shared by the command word decoder
package dxd_pkg;

   // ==========================================
   // command classes, one-hot
   typedef enum logic [4:0] {
      DXD_CMD_SPECIAL = 5'h01,
      DXD_CMD_DAC = 5'h02,
      DXD_CMD_XOUT = 5'h04,
      DXD_CMD_XIN = 5'h08,
      DXD_CMD_DIR = 5'h10
   } dxd_cmd_t;

endpackage

// file: dxd_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module dxd_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic resetn_i,
   // async in, synced out
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);

   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;

   // first flop feeds only the second
   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         meta_ff <= RST;
         sync_ff <= RST;
      end
      else
      begin
         meta_ff <= async_i;
         sync_ff <= meta_ff;
      end
   end

   assign sync_o = sync_ff;

endmodule

// file: dxd_shift.sv
// 16-bit serial shift register with parallel load and serial output latch
`timescale 1ns/10ps
`include "dxd_params.svh"
module dxd_shift (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic resetn_i,
   // serial side
   input wire logic shift_en_i,
   input wire logic out_en_i,
   input wire logic sdi_i,
   output logic sdo_o,
   // parallel side
   input wire logic load_en_i,
   input wire logic [11:0] load_val_i,
   input wire logic clr_hi_i,
   output logic [15:0] word_o
);

   logic [15:0] sr_ff;
   logic [15:0] nxt_sr;
   logic sdo_ff;

   // lsb leaves first, so new bits enter at the top
   always_comb
   begin
      nxt_sr = sr_ff;
      if (shift_en_i)
         nxt_sr = {sdi_i, sr_ff[15:1]};
      if (load_en_i)
         nxt_sr[15:4] = load_val_i;
      if (clr_hi_i)
         nxt_sr[15:8] = 8'h00;
   end

   // power-on gives zero; soft reset only clears the high byte
   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         sr_ff <= `DXD_SR_RST;
      else
         sr_ff <= nxt_sr;
   end

   // serial out changes only when out_en_i is high: a falling shift clock edge or select falling
   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         sdo_ff <= 1'b0;
      else if (out_en_i)
         sdo_ff <= sr_ff[0];
   end

   assign word_o = sr_ff;
   assign sdo_o = sdo_ff;

endmodule

// file: dxd_word_decoder.sv
// serial command word decoder for a twelve channel d/a converter with pin expander
//
// Functional notes
// - low nibble selects special, channel 1..12, expander out, expander in, direction
// - while select low, serial bit shifts in on each rising shift clock
// - select falling enables shifting; select rising executes the held word
// - lsb driven out on falling shift clock; serial output off while select high
// - special code 1100 loads the high byte into every d/a register
// - special code 1101 turns off analog drive on the eight shared pins
// - special code 1110 restores power-on state except output register and low shift byte; other special codes do nothing
// - channel 1..12 with code 0000 loads that channel's d/a register
// - code 0001 turns off one channel's analog drive, channels five to twelve only
// - expander out copies word bits 4..15 to pins 0..11 via output register
// - only pins marked output in the direction register are driven
// - expander in captures pins 0..11 into shift register bits 4..15
// - captured value is zero for output pins and analog driving pins
// - direction word: one makes a pin output, zero makes it input
// - at power-on channels 1..4 drive low, all expander pins are inputs
// - soft reset clears high shift byte, d/a, analog mode and direction registers only
// - direction register wins over every other setting of a pin
// - analog on/off still recorded while direction is one; restored when zero
// - d/a value write brings a tri-stated shared channel back to analog drive
`timescale 1ns/10ps
`include "dxd_params.svh"
module dxd_word_decoder #(
   parameter int NCH = 12,
   parameter int NPIN = 12
) (
   // clock and power-on reset
   input wire logic core_clk_i,
   input wire logic resetn_i,
   // serial link pins
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic sdi_i,
   output logic sdo_o,
   output logic sdo_oe_o,
   // expander pins
   input wire logic [NPIN-1:0] exp_pin_i,
   output logic [NPIN-1:0] exp_pin_o,
   output logic [NPIN-1:0] exp_pin_oe_o,
   // converter side: codes of channel 1 in bits 7..0 upward, and drive enables
   output logic [NCH*8-1:0] dac_code_o,
   output logic [NCH-1:0] analog_drive_o
);

   import dxd_pkg::*;

   // ==========================================
   // decode helpers
   function automatic dxd_cmd_t classify(input logic [3:0] ch);
      dxd_cmd_t k;
      k = DXD_CMD_DAC;
      if (ch == `DXD_CH_SPECIAL)
         k = DXD_CMD_SPECIAL;
      else if (ch == `DXD_CH_XOUT)
         k = DXD_CMD_XOUT;
      else if (ch == `DXD_CH_XIN)
         k = DXD_CMD_XIN;
      else if (ch == `DXD_CH_DIR)
         k = DXD_CMD_DIR;
      return k;
   endfunction

   function automatic logic is_shared(input logic [3:0] ch);
      return (ch >= `DXD_CH_SHARED_FIRST) && (ch <= `DXD_CH_LAST);
   endfunction

   // ==========================================
   // pin synchronisers
   logic sclk_s;
   logic cs_n_s;
   logic sdi_s;
   logic [NPIN-1:0] pin_s;

   dxd_sync #(.W(3), .RST(3'h2)) u_link_sync (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .async_i({sclk_i, cs_n_i, sdi_i}),
      .sync_o({sclk_s, cs_n_s, sdi_s})
   );

   dxd_sync #(.W(NPIN), .RST('0)) u_pin_sync (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .async_i(exp_pin_i),
      .sync_o(pin_s)
   );

   // ==========================================
   // link edge detection
   logic sclk_d_ff;
   logic cs_n_d_ff;

   // previous synced levels; reset assumes an idle link
   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         sclk_d_ff <= 1'b0;
         cs_n_d_ff <= 1'b1;
      end
      else
      begin
         sclk_d_ff <= sclk_s;
         cs_n_d_ff <= cs_n_s;
      end
   end

   wire sclk_rise = sclk_s & ~sclk_d_ff;
   wire sclk_fall = ~sclk_s & sclk_d_ff;
   wire cs_fall = ~cs_n_s & cs_n_d_ff;
   wire cs_rise = cs_n_s & ~cs_n_d_ff;
   wire shift_en = sclk_rise & ~cs_n_s;
   wire out_en = (sclk_fall & ~cs_n_s) | cs_fall;

   // ==========================================
   // shift register
   logic [15:0] word;
   logic [NPIN-1:0] cap_val;
   logic cap_en;
   logic soft_rst;

   dxd_shift u_shift (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .shift_en_i(shift_en),
      .out_en_i(out_en),
      .sdi_i(sdi_s),
      .sdo_o(sdo_o),
      .load_en_i(cap_en),
      .load_val_i(cap_val),
      .clr_hi_i(soft_rst),
      .word_o(word)
   );

   // serial output only while selected
   assign sdo_oe_o = ~cs_n_s;

   // ==========================================
   // command decode, acted on at select rising
   wire [3:0] chan = word[`DXD_CHAN_MSB:`DXD_CHAN_LSB];
   wire [3:0] sub = word[`DXD_SUB_MSB:`DXD_SUB_LSB];
   wire [7:0] code = word[`DXD_CODE_MSB:`DXD_CODE_LSB];
   wire [NPIN-1:0] xpay = word[`DXD_CODE_MSB:`DXD_XPAY_LSB];
   dxd_cmd_t kind;
   assign kind = classify(chan);
   wire exec = cs_rise;

   logic all_load;
   logic all_hiz;
   logic dac_load;
   logic ch_hiz;
   logic xout_wr;
   logic dir_wr;

   // one strobe per action; unlisted codes raise none
   always_comb
   begin
      all_load = 1'b0;
      all_hiz = 1'b0;
      soft_rst = 1'b0;
      dac_load = 1'b0;
      ch_hiz = 1'b0;
      xout_wr = 1'b0;
      cap_en = 1'b0;
      dir_wr = 1'b0;
      if (exec)
      begin
         unique case (kind)
            DXD_CMD_SPECIAL:
            begin
               all_load = (sub == `DXD_SUB_ALL_LOAD);
               all_hiz = (sub == `DXD_SUB_ALL_HIZ);
               soft_rst = (sub == `DXD_SUB_RESET);
            end
            DXD_CMD_DAC:
            begin
               dac_load = (sub == `DXD_SUB_LOAD);
               ch_hiz = (sub == `DXD_SUB_HIZ) && is_shared(chan);
            end
            DXD_CMD_XOUT: xout_wr = 1'b1;
            DXD_CMD_XIN: cap_en = 1'b1;
            DXD_CMD_DIR: dir_wr = 1'b1;
         endcase
      end
   end

   // ==========================================
   // d/a registers
   logic [7:0] dac_ff [NCH];

   genvar gi;
   generate
      for (gi = 0; gi < NCH; gi++)
      begin : g_dac
         wire hit = dac_load && (chan == 4'(gi + 1));
         // cleared at power-on and by soft reset, so channels 1..4 sit low
         always_ff @(posedge core_clk_i or negedge resetn_i)
         begin
            if (!resetn_i)
               dac_ff[gi] <= `DXD_DAC_RST;
            else if (soft_rst)
               dac_ff[gi] <= `DXD_DAC_RST;
            else if (all_load)
               dac_ff[gi] <= code;
            else if (hit)
               dac_ff[gi] <= code;
         end
         assign dac_code_o[gi*8 +: 8] = dac_ff[gi];
      end
   endgenerate

   // ==========================================
   // shared pin analog mode, indexed by pin 4..11 as bit 0..7
   logic [7:0] ana_en_ff;
   logic [7:0] nxt_ana_en;

   // pin k+4 carries channel 12-k; kept apart from direction so it survives
   always_comb
   begin
      nxt_ana_en = ana_en_ff;
      for (int k = 0; k < 8; k++)
      begin
         if (dac_load && (chan == 4'(12 - k)))
            nxt_ana_en[k] = 1'b1;
         if (ch_hiz && (chan == 4'(12 - k)))
            nxt_ana_en[k] = 1'b0;
      end
      if (all_load)
         nxt_ana_en = 8'hFF;
      if (all_hiz || soft_rst)
         nxt_ana_en = 8'h00;
   end

   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         ana_en_ff <= 8'h00;
      else
         ana_en_ff <= nxt_ana_en;
   end

   // ==========================================
   // direction and parallel output registers
   logic [NPIN-1:0] dir_ff;
   logic [NPIN-1:0] par_ff;

   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         dir_ff <= `DXD_DIR_RST;
      else if (soft_rst)
         dir_ff <= `DXD_DIR_RST;
      else if (dir_wr)
         dir_ff <= xpay;
   end

   // soft reset leaves this register alone on purpose
   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         par_ff <= `DXD_PAR_RST;
      else if (xout_wr)
         par_ff <= xpay;
   end

   // ==========================================
   // pin resolution; direction has the last word
   wire [NPIN-1:0] ana_pin = {ana_en_ff & ~dir_ff[11:4], 4'h0};
   assign exp_pin_o = par_ff;
   assign exp_pin_oe_o = dir_ff;

   // zero for output pins and analog pins; host drops the low nibble
   assign cap_val = pin_s & ~dir_ff & ~ana_pin;

   // channels 1..4 always drive, shared ones per mode and direction
   generate
      for (gi = 0; gi < NCH; gi++)
      begin : g_drive
         if (gi < 4)
         begin : g_fixed
            assign analog_drive_o[gi] = 1'b1;
         end
         else
         begin : g_shared
            assign analog_drive_o[gi] = ana_pin[15 - gi];
         end
      end
   endgenerate

   // ==========================================
   // checks
   AST_SDO_LSB: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      (sclk_fall && !cs_n_s) |=> (sdo_o == $past(word[0])))
      else $error("serial output missed the shift register lsb");
   AST_ONE_LOAD: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      (dac_load && chan == 4'h5) |=> (dac_code_o[39:32] == $past(code)))
      else $error("channel load did not store the code");
   AST_ALL_LOAD: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      all_load |=> (dac_code_o[7:0] == $past(code)) && (dac_code_o[95:88] == $past(code)))
      else $error("broadcast load missed a channel");
   AST_SHARED_OFF: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      all_hiz |=> (analog_drive_o[11:4] == 8'h00) && (analog_drive_o[3:0] == 4'hF))
      else $error("shared analog drive still on");
   AST_SOFT_RST: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      soft_rst |=> (exp_pin_oe_o == 12'h000) && (dac_code_o == '0) && $stable(exp_pin_o))
      else $error("soft reset state wrong");
   AST_XOUT: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      xout_wr |=> (exp_pin_o == $past(xpay)))
      else $error("expander output not transferred");
   AST_DIR_WINS: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      exp_pin_oe_o[11] |-> !analog_drive_o[4])
      else $error("pin driven both digital and analog");
   AST_DIR_WR: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      dir_wr |=> (exp_pin_oe_o == $past(xpay)))
      else $error("direction write lost");
   AST_CAPTURE: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      cap_en |=> ((word[15:4] & $past(exp_pin_oe_o)) == 12'h000))
      else $error("output pin captured as nonzero");
   AST_IGNORE: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      (exec && kind == DXD_CMD_SPECIAL && sub != 4'hC && sub != 4'hD && sub != 4'hE)
      |=> $stable(dac_code_o) && $stable(analog_drive_o) && $stable(exp_pin_oe_o))
      else $error("don't care code changed state");
   AST_REDRIVE: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      (dac_load && chan == 4'h5 && !exp_pin_oe_o[11]) |=> analog_drive_o[4])
      else $error("value write did not restore analog drive");
   AST_CH_OFF: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      (ch_hiz && chan == 4'h5) |=> !analog_drive_o[4] ##1 !analog_drive_o[4])
      else $error("single channel tri-state failed");

endmodule

// file: dxd_host_model.sv
// host side model of the serial command link
`timescale 1ns/10ps
module dxd_host_model (
   // clock
   input wire logic core_clk_i,
   // link pins
   output logic sclk_o,
   output logic cs_n_o,
   output logic sdi_o,
   input wire logic sdo_i
);
   // ==========================================
   // idle levels
   // shift clock stands still low outside frames
   initial
   begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      sdi_o = 1'b0;
   end

   // ==========================================
   // one frame: select low, 16 bits lsb first, select high
   // low phase 5 clocks, high 3: 160 ns, so sdo has settled long before it is sampled
   task automatic xfer(input logic [15:0] w, output logic [15:0] rd);
      int i;
      @(posedge core_clk_i);
      cs_n_o <= 1'b0;
      repeat (4) @(posedge core_clk_i);
      for (i = 0; i < 16; i++)
      begin
         sdi_o <= w[i];
         repeat (4) @(posedge core_clk_i);
         @(negedge core_clk_i);
         rd[i] = sdo_i;
         @(posedge core_clk_i);
         sclk_o <= 1'b1;
         repeat (3) @(posedge core_clk_i);
         sclk_o <= 1'b0;
      end
      repeat (4) @(posedge core_clk_i);
      cs_n_o <= 1'b1; // only after a whole word
      sdi_o <= ~w[15]; // released line flips so a stale bit never looks valid
      repeat (8) @(posedge core_clk_i);
   endtask
endmodule

// file: dxd_word_decoder_tb_top.sv
// self-checking bench for the serial command word decoder
`timescale 1ns/10ps
module dxd_word_decoder_tb_top;
   // ==========================================
   // clock, reset and pins
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic [11:0] ext_lvl = 12'h000;
   wire logic sclk, cs_n, sdi, sdo, sdo_oe;
   wire logic sdo_line;
   wire logic [11:0] pin_o, pin_oe, pin_lvl, drive;
   wire logic [95:0] dac_code;
   int fails = 0;
   int compares = 0;

   always #10 core_clk = ~core_clk;

   // pin level: device drives where enabled, outside world elsewhere
   assign pin_lvl = (pin_oe & pin_o) | (~pin_oe & ext_lvl);
   // released serial line reads inverted, so a late enable shows up as bad data
   assign sdo_line = sdo_oe ? sdo : ~sdo;

   dxd_word_decoder dxd_word_decoder_inst (.core_clk_i(core_clk), .resetn_i(resetn), .sclk_i(sclk),
      .cs_n_i(cs_n), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .exp_pin_i(pin_lvl), .exp_pin_o(pin_o),
      .exp_pin_oe_o(pin_oe), .dac_code_o(dac_code), .analog_drive_o(drive));
   dxd_host_model dxd_host_model_inst (.core_clk_i(core_clk), .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi),
      .sdo_i(sdo_line));

   // ==========================================
   // helpers
   task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
      compares++;
      if (got !== exp)
      begin
         fails++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask

   function automatic logic [11:0] code(input int c);
      return {4'h0, dac_code[(c-1)*8 +: 8]};
   endfunction

   task automatic chk_codes(input logic [7:0] v);
      int c;
      for (c = 1; c <= 12; c++)
         chk("dac_code", {4'h0, v}, code(c));
   endtask

   task automatic chk_st(input logic [11:0] drv, input logic [11:0] oe);
      chk("analog_drive", drv, drive);
      chk("pin_oe", oe, pin_oe);
   endtask

   // results land a few clocks after select rises; look off the edge
   task automatic send(input logic [15:0] w);
      logic [15:0] d;
      dxd_host_model_inst.xfer(w, d);
      @(negedge core_clk);
   endtask

   task test_done;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // ==========================================
   // scenarios
   task t_reset;
      chk_codes(8'h00);
      chk_st(12'h00F, 12'h000);
      chk("sdo_oe", 12'h000, {11'h0, sdo_oe});
      $display("reset_state done");
   endtask

   task t_dac;
      send(16'h5A01);
      send(16'hC30C);
      send(16'h7705);
      chk("code_ch1", 12'h05A, code(1));
      chk("code_ch12", 12'h0C3, code(12));
      chk("code_ch5", 12'h077, code(5));
      chk_st(12'h81F, 12'h000);
      $display("dac_load done");
   endtask

   // a shared channel goes off, a dedicated one and an unknown code do nothing
   task t_hiz;
      send(16'h0015);
      chk_st(12'h80F, 12'h000);
      send(16'h0012);
      chk_st(12'h80F, 12'h000);
      send(16'h9923);
      chk("code_ch3", 12'h000, code(3));
      $display("analog_off done");
   endtask

   task t_bcast;
      send(16'hABC0);
      chk_codes(8'hAB);
      chk_st(12'hFFF, 12'h000);
      send(16'h00D0);
      chk_st(12'h00F, 12'h000);
      send(16'h55F0);
      chk_codes(8'hAB);
      chk_st(12'h00F, 12'h000);
      $display("broadcast done");
   endtask

   // direction overrides analog mode on pin 11, then hands it back
   task t_dir;
      send(16'h7705);
      send(16'h800F);
      chk_st(12'h00F, 12'h800);
      send(16'h00FF);
      chk_st(12'h01F, 12'h00F);
      send(16'hA5CD);
      chk("pin_o", 12'hA5C, pin_o);
      chk("pin_driven", 12'h00C, pin_o & pin_oe);
      $display("direction_out done");
   endtask

   // outputs pins 0..3 and analog pin 11 must read as zero
   task t_xin;
      logic [15:0] rd;
      @(posedge core_clk);
      ext_lvl <= 12'hFFF;
      send(16'h000E);
      dxd_host_model_inst.xfer(16'h0000, rd);
      @(negedge core_clk);
      chk("first_nibble", 12'h00E, {8'h0, rd[3:0]});
      chk("captured", 12'h7F0, rd[15:4]);
      chk("sdo_oe", 12'h000, {11'h0, sdo_oe});
      $display("expander_in done");
   endtask

   task t_soft;
      send(16'h00E0);
      chk_codes(8'h00);
      chk_st(12'h00F, 12'h000);
      chk("pin_o", 12'hA5C, pin_o);
      send(16'h7705);
      @(posedge core_clk);
      resetn <= 1'b0;
      repeat (2) @(posedge core_clk);
      resetn <= 1'b1;
      repeat (4) @(posedge core_clk);
      @(negedge core_clk);
      chk("code_ch5", 12'h000, code(5));
      chk_st(12'h00F, 12'h000);
      $display("resets done");
   endtask

   // ==========================================
   // main sequence and hang guard
   initial
   begin
      repeat (10) @(posedge core_clk);
      resetn <= 1'b1;
      repeat (4) @(posedge core_clk);
      @(negedge core_clk);
      t_reset;
      t_dac;
      t_hiz;
      t_bcast;
      t_dir;
      t_xin;
      t_soft;
      test_done;
   end

   initial
   begin
      repeat (20000) @(posedge core_clk);
      fails++;
      $display("unexpected run length: expected end seen timeout");
      test_done;
   end
endmodule
